/* bmc_burst_ctrl.sv */
// Burst sequencing: counted and gated bursts, trigger selection, limits, marker.
//
// Operation
// - Gated burst starts on high, stops on low.
// - Source setting picks counted or gated mode.
// - Counted mode maps no-wait trigger to connector.
// - Internal timer default; interval from burst rate.
// - Bus trigger: group execute or common command.
// - Any of eight backplane lines selectable.
// - Gated: waveform while gate true, else offset.
// - Gated mode maps bus/no-wait/internal to connector.
// - Each trigger emits exactly programmed cycle count.
// - Carrier 10 mHz to 5 MHz; tri/ramp 100 kHz.
// - Minimum count rises per megahertz band to five.
// - Too-high carrier clamped down, conflict error logged.
// - Slow carrier: count over frequency at most 500s.
// - Counted marker low during burst, high after.
// - Gated marker follows waveform above offset.
// - Count 1 to 50000, or infinite; default one.
// - Disallowed count replaced by largest allowed count.
// - Edge triggers start one burst per rising edge.
// - Gated mode ignores count, rate and phase.
// - Rate 10 mHz to 50 kHz, default 100 Hz.
// - Too-fast rate stretched internally; programmed rate reads back.
// - Phase -360 to +360 degrees, held in millidegrees, default zero.
`timescale 1ns/1ps
module bmc_burst_ctrl (
  // Clock and reset
  input  wire logic                               sys_clk,
  input  wire logic                               rst_n,
  // Mode and source configuration
  input  wire logic                               burst_enable_switch,
  input  wire logic                               burst_source_select,
  input  wire logic [bmc_pkg::SRC_W-1:0]          trigger_source_select,
  input  wire logic [bmc_pkg::LINE_W-1:0]         backplane_line_select,
  input  wire logic [bmc_pkg::SHAPE_W-1:0]        carrier_shape,
  // Parameter writes
  input  wire logic                               carrier_freq_wr,
  input  wire logic [bmc_pkg::FREQ_W-1:0]         carrier_freq_req,
  input  wire logic                               cycle_count_wr,
  input  wire logic [bmc_pkg::COUNT_W-1:0]        cycle_count_req,
  input  wire logic                               cycle_count_infinite_req,
  input  wire logic                               repeat_rate_wr,
  input  wire logic [bmc_pkg::RATE_W-1:0]         repeat_rate_req,
  input  wire logic                               start_phase_wr,
  input  wire logic signed [bmc_pkg::PHASE_W-1:0] start_phase_req,
  // Bus trigger events
  input  wire logic                               group_execute_trig,
  input  wire logic                               common_trigger_command,
  // Trigger pins
  input  wire logic                               ext_trigger_pin,
  input  wire logic [bmc_pkg::LINES-1:0]          backplane_trigger_line_n,
  // Waveform synthesizer status
  input  wire logic                               carrier_cycle_done,
  input  wire logic                               wave_above_offset,
  // Waveform synthesizer control
  output logic                                    waveform_run,
  output logic                                    hold_at_offset,
  output logic                                    phase_load,
  output logic signed [bmc_pkg::PHASE_W-1:0]      start_phase,
  output logic                                    marker_out,
  // Readback
  output logic [bmc_pkg::FREQ_W-1:0]              carrier_freq,
  output logic [bmc_pkg::COUNT_W-1:0]             burst_cycle_count,
  output logic                                    cycle_count_infinite,
  output logic [bmc_pkg::RATE_W-1:0]              burst_repeat_rate,
  output logic signed [bmc_pkg::PHASE_W-1:0]      burst_start_phase,
  output logic [bmc_pkg::SRC_W-1:0]               effective_trigger_source,
  output logic                                    burst_busy,
  // Error report
  output logic                                    settings_conflict,
  output logic signed [bmc_pkg::ERR_W-1:0]        conflict_code
);
  import bmc_pkg::*;

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  function automatic logic is_slow_shape(input logic [SHAPE_W-1:0] shape);
    is_slow_shape = (shape == SHAPE_TRI) || (shape == SHAPE_RAMP);
  endfunction : is_slow_shape

  // Smallest burst count a fast carrier allows.
  function automatic logic [COUNT_W-1:0] min_count_for(input logic [FREQ_W-1:0]  freq,
                                                       input logic [SHAPE_W-1:0] shape);
    logic [COUNT_W-1:0] m;
    m = COUNT_MIN;
    if (!is_slow_shape(shape)) begin
      for (int i = 1; i < MIN_COUNT_TOP; i++) begin
        if (freq > FREQ_W'(FREQ_W'(i) * FREQ_BAND_MHZ)) begin
          m = COUNT_W'(i + 1);
        end
      end
    end
    min_count_for = m;
  endfunction : min_count_for

  // Highest carrier the shape and present count allow.
  function automatic logic [FREQ_W-1:0] max_freq_for(input logic [COUNT_W-1:0] count,
                                                     input logic               infinite,
                                                     input logic [SHAPE_W-1:0] shape);
    logic [FREQ_W-1:0] f;
    if (is_slow_shape(shape)) begin
      f = FREQ_MAX_TRI_MHZ;
    end else if (infinite || count >= COUNT_W'(MIN_COUNT_TOP)) begin
      f = FREQ_MAX_MHZ;
    end else begin
      f = FREQ_W'(FREQ_W'(count) * FREQ_BAND_MHZ);
    end
    max_freq_for = f;
  endfunction : max_freq_for

  // Mode-dependent substitution of unsupported trigger sources.
  function automatic logic [SRC_W-1:0] map_source(input logic [SRC_W-1:0] req,
                                                  input logic             gated);
    logic [SRC_W-1:0] s;
    if (gated) begin
      s = (req == SRC_BACKPLANE) ? SRC_BACKPLANE : SRC_EXTERNAL;
    end else begin
      case (req)
        SRC_INTERNAL, SRC_BUS, SRC_BACKPLANE, SRC_EXTERNAL: s = req;
        default:                                            s = SRC_EXTERNAL;
      endcase
    end
    map_source = s;
  endfunction : map_source

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [LINES:0] pin_meta_reg;
  logic [LINES:0] pin_sync_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= {ext_trigger_pin, ~backplane_trigger_line_n};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ****************************************************************
  // Trigger source selection
  // ****************************************************************
  logic             gated_mode;
  logic [SRC_W-1:0] src_eff;
  logic             sel_level;
  logic             sel_level_prev_reg;
  logic             sel_rise;

  assign gated_mode = burst_source_select;
  assign src_eff    = map_source(trigger_source_select, gated_mode);

  // Backplane lines are active low; the synchroniser stores them as "true".
  always_comb begin
    case (src_eff)
      SRC_BACKPLANE: sel_level = pin_sync_reg[backplane_line_select];
      default:       sel_level = pin_sync_reg[LINES];
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sel_level_prev_reg <= 1'b0;
    end else begin
      sel_level_prev_reg <= sel_level;
    end
  end

  assign sel_rise = sel_level & ~sel_level_prev_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      effective_trigger_source <= SRC_INTERNAL;
    end else begin
      effective_trigger_source <= src_eff;
    end
  end

  // ****************************************************************
  // Parameter store and conflict checks
  // ****************************************************************
  logic [FREQ_W-1:0]  freq_clip;
  logic [FREQ_W-1:0]  freq_next;
  logic [FREQ_W-1:0]  freq_low_floor;
  logic               freq_conflict;
  logic [COUNT_W-1:0] count_clip;
  logic [COUNT_W-1:0] count_next;
  logic [COUNT_W-1:0] count_ceiling;

  always_comb begin
    freq_clip = carrier_freq_req;
    if (freq_clip < FREQ_MIN_MHZ) begin
      freq_clip = FREQ_MIN_MHZ;
    end
    freq_next      = freq_clip;
    freq_conflict  = 1'b0;
    freq_low_floor = FREQ_W'(FREQ_W'(burst_cycle_count) * FREQ_W'(MIN_MHZ_PER_CYCLE));
    if (freq_clip > max_freq_for(burst_cycle_count, cycle_count_infinite, carrier_shape)) begin
      freq_next     = max_freq_for(burst_cycle_count, cycle_count_infinite, carrier_shape);
      freq_conflict = 1'b1;
    end else if (!cycle_count_infinite && freq_clip <= FREQ_LOWBAND_MHZ &&
                 freq_clip < freq_low_floor) begin
      // Above the low band no duration limit applies, so the floor is either
      // the exact bound or the first value past the band.
      freq_next     = (freq_low_floor <= FREQ_LOWBAND_MHZ) ? freq_low_floor
                                                           : FREQ_LOWBAND_MHZ + FREQ_W'(1);
      freq_conflict = 1'b1;
    end
  end

  always_comb begin
    count_clip = cycle_count_req;
    if (count_clip < COUNT_MIN) begin
      count_clip = COUNT_MIN;
    end else if (count_clip > COUNT_MAX) begin
      count_clip = COUNT_MAX;
    end
    if (carrier_freq <= FREQ_LOWBAND_MHZ) begin
      count_ceiling = COUNT_W'(carrier_freq >> 1);
      if (count_ceiling < COUNT_MIN) begin
        count_ceiling = COUNT_MIN;
      end
    end else begin
      count_ceiling = COUNT_MAX;
    end
    count_next = count_clip;
    if (count_clip > count_ceiling ||
        count_clip < min_count_for(carrier_freq, carrier_shape)) begin
      count_next = count_ceiling;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      carrier_freq <= FREQ_DEFAULT_MHZ;
    end else if (carrier_freq_wr) begin
      carrier_freq <= freq_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      burst_cycle_count    <= COUNT_DEFAULT;
      cycle_count_infinite <= 1'b0;
    end else if (cycle_count_wr) begin
      cycle_count_infinite <= cycle_count_infinite_req;
      if (!cycle_count_infinite_req) begin
        burst_cycle_count <= count_next;
      end
    end
  end

  // The programmed rate is kept as written; stretching happens in the trigger path.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      burst_repeat_rate <= RATE_DEFAULT_MHZ;
    end else if (repeat_rate_wr) begin
      if (repeat_rate_req < RATE_MIN_MHZ) begin
        burst_repeat_rate <= RATE_MIN_MHZ;
      end else if (repeat_rate_req > RATE_MAX_MHZ) begin
        burst_repeat_rate <= RATE_MAX_MHZ;
      end else begin
        burst_repeat_rate <= repeat_rate_req;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      burst_start_phase <= PHASE_DEFAULT;
    end else if (start_phase_wr) begin
      if (start_phase_req > PHASE_MAX) begin
        burst_start_phase <= PHASE_MAX;
      end else if (start_phase_req < -PHASE_MAX) begin
        burst_start_phase <= -PHASE_MAX;
      end else begin
        burst_start_phase <= start_phase_req;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      settings_conflict <= 1'b0;
      conflict_code     <= '0;
    end else begin
      settings_conflict <= carrier_freq_wr & freq_conflict;
      if (carrier_freq_wr && freq_conflict) begin
        conflict_code <= ERR_SETTINGS_CONFLICT;
      end
    end
  end

  // ****************************************************************
  // Internal trigger timer
  // ****************************************************************
  logic counted_on;
  logic timer_tick;
  logic timer_pending_reg;
  logic trigger_event;
  logic burst_start;

  assign counted_on = burst_enable_switch & ~gated_mode;

  bmc_rate_timer u_rate_timer (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .run      (counted_on && src_eff == SRC_INTERNAL),
    .rate_mhz (burst_repeat_rate),
    .tick     (timer_tick)
  );

  // A tick that lands while a burst is still running stays pending, so a too-fast
  // rate stretches the interval instead of dropping bursts. Set wins over clear.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !counted_on || src_eff != SRC_INTERNAL) begin
      timer_pending_reg <= 1'b0;
    end else begin
      timer_pending_reg <= timer_tick | (timer_pending_reg & ~burst_start);
    end
  end

  always_comb begin
    case (src_eff)
      SRC_INTERNAL: trigger_event = timer_pending_reg;
      SRC_BUS:      trigger_event = group_execute_trig | common_trigger_command;
      default:      trigger_event = sel_rise;
    endcase
  end

  // ****************************************************************
  // Counted burst sequencer
  // ****************************************************************
  bmc_state_t         state_reg;
  logic [COUNT_W-1:0] remaining_reg;
  logic               last_cycle;

  assign burst_start = counted_on && state_reg == BMC_IDLE && trigger_event;
  assign last_cycle  = carrier_cycle_done && !cycle_count_infinite &&
                       remaining_reg == COUNT_MIN;
  assign burst_busy  = (state_reg == BMC_RUN);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= BMC_IDLE;
    end else begin
      case (state_reg)
        BMC_IDLE: begin
          if (burst_start) begin
            state_reg <= BMC_RUN;
          end
        end
        BMC_RUN: begin
          if (!counted_on || last_cycle) begin
            state_reg <= BMC_IDLE;
          end
        end
        default: state_reg <= BMC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      remaining_reg <= COUNT_DEFAULT;
    end else if (burst_start) begin
      remaining_reg <= burst_cycle_count;
    end else if (state_reg == BMC_RUN && carrier_cycle_done && !cycle_count_infinite) begin
      remaining_reg <= remaining_reg - COUNT_MIN;
    end
  end

  // Phase is handed over only at a counted start; gated bursts never load it.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phase_load  <= 1'b0;
      start_phase <= PHASE_DEFAULT;
    end else begin
      phase_load <= burst_start;
      if (burst_start) begin
        start_phase <= burst_start_phase;
      end
    end
  end

  // ****************************************************************
  // Output gating and marker
  // ****************************************************************
  logic run_next;

  always_comb begin
    if (!burst_enable_switch) begin
      run_next = 1'b0;
    end else if (gated_mode) begin
      run_next = sel_level;
    end else begin
      run_next = burst_start || (state_reg == BMC_RUN && !last_cycle);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      waveform_run <= 1'b0;
    end else begin
      waveform_run <= run_next;
    end
  end

  assign hold_at_offset = ~waveform_run;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      marker_out <= 1'b1;
    end else if (gated_mode) begin
      marker_out <= waveform_run & wave_above_offset;
    end else begin
      marker_out <= ~run_next;
    end
  end

endmodule : bmc_burst_ctrl

/* bmc_chk.sv */
// Port assertions for the burst controller.
`timescale 1ns/1ps
module bmc_chk import bmc_pkg::*; (
  // Clock, reset and controls
  input wire logic sys_clk, rst_n, burst_enable_switch, burst_source_select,
  input wire logic [SRC_W-1:0] trigger_source_select, effective_trigger_source,
  input wire logic group_execute_trig, common_trigger_command, wave_above_offset, ext_trigger_pin,
  // Outputs
  input wire logic waveform_run, hold_at_offset, phase_load, marker_out, burst_busy,
  input wire logic settings_conflict, cycle_count_infinite,
  input wire logic signed [PHASE_W-1:0] start_phase, burst_start_phase,
  input wire logic signed [ERR_W-1:0] conflict_code,
  input wire logic [FREQ_W-1:0] carrier_freq,
  input wire logic [COUNT_W-1:0] burst_cycle_count
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire gated = burst_enable_switch && burst_source_select;
  sequence bus_req;
    burst_enable_switch && !burst_source_select && !burst_busy && effective_trigger_source == SRC_BUS
      && (group_execute_trig || common_trigger_command);
  endsequence
  sequence started;
    waveform_run && phase_load && !marker_out && burst_busy;
  endsequence
  a_bus_start: assert property (bus_req |=> started) else $error("bus trigger lost");
  a_offset_hold: assert property (gated && $past(gated) && effective_trigger_source == SRC_EXTERNAL
    |-> hold_at_offset == !$past(ext_trigger_pin, 3)) else $error("offset hold");
  a_busy_marker: assert property (burst_busy |-> !marker_out) else $error("marker high in burst");
  a_end_marker: assert property (burst_enable_switch && !burst_source_select && $fell(burst_busy)
    |-> marker_out) else $error("marker low after burst");
  a_gate_marker: assert property (gated && $past(gated)
    |-> marker_out == $past(waveform_run && wave_above_offset)) else $error("gated marker");
  a_gate_phase: assert property (gated && $past(gated) |-> !phase_load) else $error("gated phase load");
  a_phase_load: assert property ($rose(waveform_run) && !burst_source_select
    |-> phase_load && start_phase == $past(burst_start_phase)) else $error("start phase");
  a_conflict_code: assert property (settings_conflict
    |-> conflict_code == ERR_SETTINGS_CONFLICT) else $error("conflict code");
  a_freq_range: assert property (carrier_freq inside {[FREQ_MIN_MHZ:FREQ_MAX_MHZ]})
    else $error("frequency range");
  a_count_range: assert property (cycle_count_infinite || burst_cycle_count inside {[COUNT_MIN:COUNT_MAX]})
    else $error("count range");
  a_gate_source: assert property (burst_source_select && trigger_source_select <= SRC_BUS
    ##1 burst_source_select && $stable(trigger_source_select)
    |=> effective_trigger_source == SRC_EXTERNAL) else $error("gated source");
endmodule : bmc_chk
bind bmc_burst_ctrl bmc_chk u_chk (.*);

/* bmc_pkg.sv */
// Shared constants for the burst modulation control block.
package bmc_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int FREQ_W   = 34;   // Carrier frequency in millihertz.
  localparam int COUNT_W  = 16;   // Burst cycle count.
  localparam int RATE_W   = 32;   // Burst repeat rate in millihertz.
  localparam int PHASE_W  = 20;   // Signed start phase in millidegrees.
  localparam int SRC_W    = 3;
  localparam int SHAPE_W  = 3;
  localparam int LINES    = 8;    // Backplane trigger lines 0..7.
  localparam int LINE_W   = 3;
  localparam int ACC_W    = 36;
  localparam int ERR_W    = 16;

  // ****************************************************************
  // Trigger source and shape codes
  // ****************************************************************
  localparam logic [SRC_W-1:0] SRC_NO_WAIT   = 3'h0;  // no_wait_trigger request
  localparam logic [SRC_W-1:0] SRC_INTERNAL  = 3'h1;
  localparam logic [SRC_W-1:0] SRC_BUS       = 3'h2;
  localparam logic [SRC_W-1:0] SRC_EXTERNAL  = 3'h3;
  localparam logic [SRC_W-1:0] SRC_BACKPLANE = 3'h4;

  localparam logic [SHAPE_W-1:0] SHAPE_SINE   = 3'h0;
  localparam logic [SHAPE_W-1:0] SHAPE_SQUARE = 3'h1;
  localparam logic [SHAPE_W-1:0] SHAPE_TRI    = 3'h2;
  localparam logic [SHAPE_W-1:0] SHAPE_RAMP   = 3'h3;
  localparam logic [SHAPE_W-1:0] SHAPE_ARB    = 3'h4;

  // ****************************************************************
  // Frequency, count, rate and phase limits
  // ****************************************************************
  localparam logic [FREQ_W-1:0] FREQ_MIN_MHZ     = 34'hA;           // 10 mHz
  localparam logic [FREQ_W-1:0] FREQ_MAX_MHZ     = 34'h1_2A05_F200; // 5 MHz
  localparam logic [FREQ_W-1:0] FREQ_MAX_TRI_MHZ = 34'h5F5_E100;    // 100 kHz
  localparam logic [FREQ_W-1:0] FREQ_BAND_MHZ    = 34'h3B9A_CA00;   // 1 MHz
  localparam logic [FREQ_W-1:0] FREQ_LOWBAND_MHZ = 34'h1_86A0;      // 100 Hz
  localparam logic [FREQ_W-1:0] FREQ_DEFAULT_MHZ = 34'hF_4240;      // 1 kHz
  localparam int                MIN_COUNT_TOP    = 5;

  localparam logic [COUNT_W-1:0] COUNT_MIN     = 16'h1;
  localparam logic [COUNT_W-1:0] COUNT_MAX     = 16'hC350;          // 50000
  localparam logic [COUNT_W-1:0] COUNT_DEFAULT = 16'h1;

  localparam logic [RATE_W-1:0] RATE_MIN_MHZ     = 32'hA;           // 10 mHz
  localparam logic [RATE_W-1:0] RATE_MAX_MHZ     = 32'h2FA_F080;    // 50 kHz
  localparam logic [RATE_W-1:0] RATE_DEFAULT_MHZ = 32'h1_86A0;      // 100 Hz

  localparam logic signed [PHASE_W-1:0] PHASE_MAX     = 20'sh5_7E40; // 360.000 deg
  localparam logic signed [PHASE_W-1:0] PHASE_DEFAULT = 20'sh0;

  // Longest slow burst is 500 s, so frequency in mHz must be at least
  // count times (1000 / 500).
  localparam int LONG_BURST_S      = 32'h1F4;
  localparam int MHZ_PER_HZ        = 32'h3E8;
  localparam int MIN_MHZ_PER_CYCLE = MHZ_PER_HZ / LONG_BURST_S;

  localparam logic signed [ERR_W-1:0] ERR_SETTINGS_CONFLICT = 16'shFF23; // -221

  // ****************************************************************
  // Clock
  // ****************************************************************
  localparam int CLK_HZ = 32'h017D_7840;  // 25 MHz
  localparam logic [ACC_W-1:0] TIMER_WRAP_MHZ = ACC_W'(CLK_HZ) * ACC_W'(MHZ_PER_HZ);

  typedef enum logic [1:0] {
    BMC_IDLE = 2'b01,
    BMC_RUN  = 2'b10
  } bmc_state_t;

endpackage : bmc_pkg

/* bmc_rate_timer.sv */
// Internal trigger timer: fractional accumulator producing burst-rate ticks.
`timescale 1ns/1ps
module bmc_rate_timer (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  // Control
  input  wire logic                       run,
  input  wire logic [bmc_pkg::RATE_W-1:0] rate_mhz,
  // Event
  output logic                            tick
);
  import bmc_pkg::*;

  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] sum;

  // The accumulator gains the rate each cycle and wraps at the clock rate in
  // millihertz, so tick spacing averages exactly one rate period without a divider.
  assign sum = acc_reg + ACC_W'(rate_mhz);

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !run) begin
      acc_reg <= '0;
      tick    <= 1'b0;
    end else if (sum >= TIMER_WRAP_MHZ) begin
      acc_reg <= sum - TIMER_WRAP_MHZ;
      tick    <= 1'b1;
    end else begin
      acc_reg <= sum;
      tick    <= 1'b0;
    end
  end

endmodule : bmc_rate_timer

/* bmc_synth_model.sv */
// Waveform synthesizer stand-in for the burst controller bench.
`timescale 1ns/1ps
module bmc_synth_model (
  // Clock and control
  input  wire logic sys_clk,
  input  wire logic waveform_run,
  // Status
  output logic      carrier_cycle_done,
  output logic      wave_above_offset
);
  logic [1:0] phase_reg = 2'h0;
  logic [1:0] free_reg  = 2'h0;
  // A carrier cycle lasts three clocks, so the run length shows the count.
  always_ff @(posedge sys_clk) begin
    phase_reg <= (waveform_run && phase_reg != 2'h2) ? phase_reg + 2'h1 : 2'h0;
  end
  always_ff @(posedge sys_clk) begin
    free_reg <= free_reg + 2'h1;
  end
  assign carrier_cycle_done = waveform_run && phase_reg == 2'h2;
  assign wave_above_offset  = free_reg[1];
endmodule : bmc_synth_model

/* testbench.sv */
// Self-checking bench for the burst controller.
`timescale 1ns/1ps
module testbench;
  import bmc_pkg::*;
  logic sys_clk = '0, rst_n = '0, burst_enable_switch = '0, burst_source_select = '0;
  logic carrier_freq_wr = '0, cycle_count_wr = '0, repeat_rate_wr = '0, start_phase_wr = '0;
  logic cycle_count_infinite_req = '0, group_execute_trig = '0, common_trigger_command = '0;
  logic ext_trigger_pin = '0, carrier_cycle_done, wave_above_offset;
  logic [SRC_W-1:0] trigger_source_select = SRC_BUS, effective_trigger_source;
  logic [LINE_W-1:0] backplane_line_select = '0;
  logic [SHAPE_W-1:0] carrier_shape = SHAPE_SINE;
  logic [FREQ_W-1:0] carrier_freq_req = '0, carrier_freq;
  logic [COUNT_W-1:0] cycle_count_req = '0, burst_cycle_count;
  logic [RATE_W-1:0] repeat_rate_req = '0, burst_repeat_rate, r;
  logic signed [PHASE_W-1:0] start_phase_req = '0, start_phase, burst_start_phase, ph;
  logic [LINES-1:0] backplane_trigger_line_n = '1;
  logic waveform_run, hold_at_offset, phase_load, marker_out, cycle_count_infinite;
  logic burst_busy, settings_conflict;
  logic signed [ERR_W-1:0] conflict_code;
  logic [SRC_W-1:0] src [6] = '{SRC_BUS, SRC_BUS, SRC_NO_WAIT, SRC_EXTERNAL, SRC_BACKPLANE, SRC_INTERNAL};
  int bad_count = 0, tests_run = 0, cyc = 0, n, l;
  bmc_burst_ctrl dut (.*);
  bmc_synth_model synth (.*);
  initial forever #20 sys_clk = !sys_clk;
  // A hung handshake must still reach the verdict.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tk(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask : tk
  task automatic wr(input int k, input logic [35:0] v);
    @(posedge sys_clk);
    carrier_freq_req <= v[FREQ_W-1:0];
    cycle_count_req <= v[COUNT_W-1:0];
    repeat_rate_req <= v[RATE_W-1:0];
    start_phase_req <= v[PHASE_W-1:0];
    {carrier_freq_wr, cycle_count_wr, repeat_rate_wr, start_phase_wr} <= 4'h8 >> k;
    @(posedge sys_clk);
    {carrier_freq_wr, cycle_count_wr, repeat_rate_wr, start_phase_wr} <= 4'h0;
    #1;
  endtask : wr
  task automatic burst(input int n);
    int cnt = 0;
    for (int k = 0; k < 1200 && waveform_run !== 1'b1; k++) @(posedge sys_clk) #1;
    chk({phase_load, start_phase}, {1'b1, ph});
    while (waveform_run === 1'b1 && cnt <= n) begin
      if (carrier_cycle_done === 1'b1) cnt++;
      @(posedge sys_clk) #1;
    end
    chk(cnt, n);
    chk(marker_out, 1'b1);
  endtask : burst
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  initial begin
    void'($urandom(32'h829954D1));
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 chk({burst_cycle_count, burst_start_phase}, {COUNT_DEFAULT, PHASE_DEFAULT});
    chk({effective_trigger_source, carrier_freq}, {SRC_INTERNAL, FREQ_DEFAULT_MHZ});
    chk(burst_repeat_rate, RATE_DEFAULT_MHZ);
    wr(0, 36'h1_65A0_BC00);
    chk({settings_conflict, conflict_code, carrier_freq}, {1'b1, ERR_SETTINGS_CONFLICT, FREQ_BAND_MHZ});
    wr(1, 36'h5);
    wr(0, FREQ_MAX_MHZ);
    chk({settings_conflict, carrier_freq}, {1'b0, FREQ_MAX_MHZ});
    wr(1, 36'hEA60);
    chk(burst_cycle_count, COUNT_MAX);
    wr(1, 36'h2);
    chk(burst_cycle_count, COUNT_MAX);
    cycle_count_infinite_req <= 1'b1;
    wr(1, 36'h2);
    chk({cycle_count_infinite, burst_cycle_count}, {1'b1, COUNT_MAX});
    cycle_count_infinite_req <= 1'b0;
    wr(1, 36'hC350);
    wr(0, 36'h64);
    chk({settings_conflict, carrier_freq}, {1'b1, 34'h1_86A0});
    wr(0, FREQ_DEFAULT_MHZ);
    r = $urandom_range(RATE_MAX_MHZ, RATE_MIN_MHZ);
    wr(2, r);
    chk(burst_repeat_rate, r);
    ph = $urandom_range(32'hAFC80) - PHASE_MAX;
    wr(3, ph);
    chk(burst_start_phase, ph);
    wr(2, RATE_MAX_MHZ);
    burst_enable_switch <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      n = $urandom_range(4, 1);
      l = $urandom_range(7);
      wr(1, n);
      trigger_source_select <= src[i];
      backplane_line_select <= l;
      tk(4);
      group_execute_trig <= i == 0;
      common_trigger_command <= i == 1;
      ext_trigger_pin <= i == 2 || i == 3;
      backplane_trigger_line_n[l] <= i != 4;
      @(posedge sys_clk);
      group_execute_trig <= 1'b0;
      common_trigger_command <= 1'b0;
      #1 burst(n);
      tk(20);
      chk(waveform_run, 1'b0);
      ext_trigger_pin <= 1'b0;
      backplane_trigger_line_n <= '1;
    end
    burst_source_select <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      trigger_source_select <= j ? SRC_BACKPLANE : SRC_BUS;
      for (int g = 1; g >= 0; g--) begin
        tk(3);
        ext_trigger_pin <= g && !j;
        backplane_trigger_line_n[l] <= !(g && j);
        tk(5);
        chk({waveform_run, hold_at_offset}, {g[0], !g[0]});
      end
      chk(effective_trigger_source, j ? SRC_BACKPLANE : SRC_EXTERNAL);
    end
    summarize();
  end
endmodule : testbench
